// file: inc/lpwm_pkg.sv
// constants, timing and helpers of the four-channel led pwm output stage
//
// Summary of operation
// - normal totem-pole: both transistors follow combined pwm
// - inverted open-drain: upper off, lower follows complement
// - inverted totem-pole: both transistors follow complemented pwm
// - output disable forces pins to chosen disabled state
// - per-channel fixed-rate pwm with 8-bit duty
// - individual pulse high time is duty times step
// - one group signal, dim or blink, for all
// - group dimming: fixed-rate 8-bit group duty
// - group blinking: 8-bit period, separate 8-bit duty
// - bus idles high; transfers only when not busy
// - one bit per clock; data stable while high
// - data fall with clock high START, rise STOP
// - every byte followed by one acknowledge bit
// - acknowledge each received byte, low through high phase
// - after missing read acknowledge, leave data high
// - sleep stops counters; outputs hold unless output disable is active
// - normal open-drain: only lower transistor switches
package lpwm_pkg;

    // ********************************
    // clock and timing
    // ********************************
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int STEPS = 256;
    localparam int IND_STEP_NS = 40;
    // a step shorter than the clock rounds up to one cycle
    localparam int IND_STEP_CYC = (IND_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIM_FREQ_HZ = 190;
    localparam int DIM_STEP_CYC = CLK_HZ / (DIM_FREQ_HZ * STEPS);
    localparam int BLINK_MAX_HZ = 24;
    localparam int BLINK_STEP_CYC = CLK_HZ / (BLINK_MAX_HZ * STEPS);

    typedef logic [11:0] lpwm_pre_t;

    // ********************************
    // field codes and reset values
    // ********************************
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_ON = 2'h1;
    localparam logic [1:0] SEL_IND = 2'h2;
    localparam logic [1:0] DIS_LOW = 2'h0;
    localparam logic [1:0] DIS_HIGH = 2'h1;
    localparam logic [3:0] RST_HI = 4'hF;
    localparam logic [3:0] RST_LO = 4'h0;
    localparam logic [3:0] BITS_BYTE = 4'h8;

    // prescaler has reached its last cycle
    function automatic logic lpwm_wrap(input lpwm_pre_t c, input int lim);
        lpwm_wrap = c >= lpwm_pre_t'(lim - 1);
    endfunction : lpwm_wrap

endpackage : lpwm_pkg

// file: logic/lpwm_i2c_target.sv
// serial two-wire write/read target with start/stop detection
`timescale 1ns/1ns
`default_nettype none
module lpwm_i2c_target
    import lpwm_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic [6:0] dev_addr, // own target address
    input wire logic scl_pin, // serial clock pin
    input wire logic sda_pin_in, // serial data pin level
    input wire logic [7:0] tx_byte, // byte to send on reads
    output logic sda_out, // data output level, always low
    output logic sda_oe_n, // data pull-down enable, low drives
    output logic [7:0] rx_byte, // last written byte
    output logic rx_valid, // one-cycle pulse per written byte
    output logic rx_first, // byte is first after address
    output logic tx_taken, // one-cycle pulse, tx_byte loaded
    output logic bus_busy // between start and stop
);

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACKA, ST_WR, ST_ACKW, ST_RD, ST_RACK} lpwm_i2c_e;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic scl;
        logic sda;
        lpwm_i2c_e st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic rw;
        logic acked;
        logic first;
        logic sda_oe_n;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic rx_first;
        logic tx_taken;
        logic busy;
    } lpwm_i2c_s;

    lpwm_i2c_s s;
    lpwm_i2c_s n;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    always_comb begin
        n = s;
        n.rx_valid = 1'b0;
        n.tx_taken = 1'b0;
        n.scl_sy = {s.scl_sy[1:0], scl_pin};
        n.sda_sy = {s.sda_sy[1:0], sda_pin_in};
        if (s.scl_sy[1] == s.scl_sy[2]) begin
            n.scl = s.scl_sy[2];
        end
        if (s.sda_sy[1] == s.sda_sy[2]) begin
            n.sda = s.sda_sy[2];
        end
        rise = n.scl && !s.scl;
        fall = !n.scl && s.scl;
        // a data change while the clock is high is a condition, not data
        start = s.scl && n.scl && s.sda && !n.sda;
        stop = s.scl && n.scl && !s.sda && n.sda;
        if (start) begin
            n.st = ST_ADDR;
            n.bits = 4'h0;
            n.sda_oe_n = 1'b1;
            n.busy = 1'b1;
        end else if (stop) begin
            n.st = ST_IDLE;
            n.sda_oe_n = 1'b1;
            n.busy = 1'b0;
        end else if (rise) begin
            case (s.st)
                ST_ADDR, ST_WR: begin
                    n.sh = {s.sh[6:0], n.sda};
                    n.bits = s.bits + 4'h1;
                end
                ST_RD: n.bits = s.bits + 4'h1;
                ST_RACK: n.acked = !n.sda;
                default: ;
            endcase
        end else if (fall) begin
            case (s.st)
                ST_ADDR: begin
                    if (s.bits == BITS_BYTE) begin
                        if (s.sh[7:1] == dev_addr) begin
                            n.st = ST_ACKA;
                            n.sda_oe_n = 1'b0;
                            n.rw = s.sh[0];
                            n.first = 1'b1;
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end
                end
                ST_WR: begin
                    if (s.bits == BITS_BYTE) begin
                        n.st = ST_ACKW;
                        n.sda_oe_n = 1'b0;
                        n.rx_byte = s.sh;
                        n.rx_valid = 1'b1;
                        n.rx_first = s.first;
                        n.first = 1'b0;
                    end
                end
                ST_ACKA, ST_ACKW, ST_RACK: begin
                    if ((s.st == ST_ACKA && s.rw) || (s.st == ST_RACK && s.acked)) begin
                        n.st = ST_RD;
                        n.sh = tx_byte;
                        n.sda_oe_n = tx_byte[7];
                        n.bits = 4'h0;
                        n.tx_taken = 1'b1;
                    end else begin
                        // no acknowledge on a read ends it with the line left high
                        n.st = (s.st == ST_RACK) ? ST_IDLE : ST_WR;
                        n.sda_oe_n = 1'b1;
                        n.bits = 4'h0;
                    end
                end
                ST_RD: begin
                    if (s.bits == BITS_BYTE) begin
                        n.st = ST_RACK;
                        n.sda_oe_n = 1'b1;
                    end else begin
                        n.sh = {s.sh[6:0], 1'b0};
                        n.sda_oe_n = s.sh[6];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{scl_sy: 3'h7, sda_sy: 3'h7, scl: 1'b1, sda: 1'b1, st: ST_IDLE, sda_oe_n: 1'b1, default: '0};
        end else begin
            s <= n;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = s.sda_oe_n;
    assign rx_byte = s.rx_byte;
    assign rx_valid = s.rx_valid;
    assign rx_first = s.rx_first;
    assign tx_taken = s.tx_taken;
    assign bus_busy = s.busy;

    // ********************************
    // checks
    // ********************************
    property p_ack_low;
        @(posedge clk) disable iff (!rst_n)
        (s.st == ST_ACKW) |-> !sda_oe_n;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("write ack not driven low");

    property p_start_addr;
        @(posedge clk) disable iff (!rst_n)
        start |=> (s.st == ST_ADDR) && bus_busy && sda_oe_n;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not taken");

    property p_nack_release;
        @(posedge clk) disable iff (!rst_n)
        (s.st == ST_RACK && fall && !s.acked && !start && !stop) |=> sda_oe_n && s.st == ST_IDLE;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("line not left high");

    property p_stop_idle;
        @(posedge clk) disable iff (!rst_n)
        stop |=> !bus_busy && sda_oe_n;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");

endmodule : lpwm_i2c_target
`default_nettype wire

// file: logic/lpwm_top.sv
// four-channel led pwm output stage with group dim/blink and serial target
`timescale 1ns/1ns
`default_nettype none
module lpwm_top
    import lpwm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10 // target address, arbitrary value
) (
    input wire logic clk, // 20 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic scl_pin, // serial clock pin
    input wire logic sda_pin_in, // serial data pin level
    output logic sda_out, // data output level
    output logic sda_oe_n, // data drive enable, low drives
    input wire logic oe_n_pin, // output enable pin, active low
    input wire logic osc_sleep, // 1 stops the pwm timebase
    input wire logic group_blink, // 0 group dimming, 1 blinking
    input wire logic output_polarity_invert, // invert channel activity
    input wire logic output_drive_type, // 1 totem-pole, 0 open-drain
    input wire logic [1:0] disabled_output_state, // pin state when disabled
    input wire logic [7:0] channel_output_select, // 2 bits per channel
    input wire logic [31:0] channel_duty_value, // 8 bits per channel
    input wire logic [7:0] group_duty_value, // group duty
    input wire logic [7:0] group_period_value, // blink period steps
    input wire logic [7:0] tx_byte, // byte returned on reads
    output logic [7:0] rx_byte, // last written byte
    output logic rx_valid, // pulse per written byte
    output logic rx_first, // first byte after address
    output logic tx_taken, // pulse, tx_byte loaded
    output logic bus_busy, // serial bus busy
    output logic [3:0] led_hi_on, // upper transistor on, per pin
    output logic [3:0] led_lo_on // lower transistor on, per pin
);

    // ********************************
    // reset release
    // ********************************
    logic [1:0] rst_sy;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sy <= 2'h0;
        end else begin
            rst_sy <= {rst_sy[0], 1'b1};
        end
    end

    assign rst_n = rst_sy[1];

    // ********************************
    // serial target
    // ********************************
    lpwm_i2c_target u_i2c (
        .clk(clk),
        .rst_n(rst_n),
        .dev_addr(DEV_ADDR),
        .scl_pin(scl_pin),
        .sda_pin_in(sda_pin_in),
        .tx_byte(tx_byte),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .rx_first(rx_first),
        .tx_taken(tx_taken),
        .bus_busy(bus_busy)
    );

    // ********************************
    // pwm state
    // ********************************
    typedef struct packed {
        logic [2:0] oe_sy;
        logic oe_f;
        lpwm_pre_t ind_pre;
        logic [7:0] ind_cnt;
        lpwm_pre_t grp_pre;
        logic [7:0] grp_sub;
        logic [7:0] grp_cnt;
        logic [3:0] hi;
        logic [3:0] lo;
    } lpwm_top_s;

    lpwm_top_s s;
    lpwm_top_s n;
    logic grp_act;

    always_comb begin
        logic a;
        logic v;
        logic [1:0] sel;
        logic [7:0] d;
        a = 1'b0;
        v = 1'b0;
        sel = 2'h0;
        d = 8'h0;
        n = s;
        n.oe_sy = {s.oe_sy[1:0], oe_n_pin};
        if (s.oe_sy[1] == s.oe_sy[2]) begin
            n.oe_f = s.oe_sy[2];
        end
        // one timebase serves all channels; sleep freezes it
        if (!osc_sleep) begin
            if (lpwm_wrap(s.ind_pre, IND_STEP_CYC)) begin
                n.ind_pre = '0;
                n.ind_cnt = s.ind_cnt + 8'h1;
            end else begin
                n.ind_pre = s.ind_pre + 12'h1;
            end
            if (lpwm_wrap(s.grp_pre, group_blink ? BLINK_STEP_CYC : DIM_STEP_CYC)) begin
                n.grp_pre = '0;
                // blink stretches each step by the period value
                if (!group_blink || s.grp_sub >= group_period_value) begin
                    n.grp_sub = 8'h0;
                    n.grp_cnt = s.grp_cnt + 8'h1;
                end else begin
                    n.grp_sub = s.grp_sub + 8'h1;
                end
            end else begin
                n.grp_pre = s.grp_pre + 12'h1;
            end
        end
        grp_act = s.grp_cnt < group_duty_value;
        for (int i = 0; i < 4; i++) begin
            sel = channel_output_select[2*i +: 2];
            d = channel_duty_value[8*i +: 8];
            case (sel)
                SEL_OFF: a = 1'b0;
                SEL_ON: a = 1'b1;
                SEL_IND: a = s.ind_cnt < d;
                default: a = (s.ind_cnt < d) && grp_act;
            endcase
            v = a ^ output_polarity_invert;
            if (s.oe_f) begin
                // disable overrides everything, even while asleep
                case (disabled_output_state)
                    DIS_LOW: begin
                        n.hi[i] = 1'b0;
                        n.lo[i] = 1'b1;
                    end
                    DIS_HIGH: begin
                        n.hi[i] = output_drive_type;
                        n.lo[i] = 1'b0;
                    end
                    default: begin
                        n.hi[i] = 1'b0;
                        n.lo[i] = 1'b0;
                    end
                endcase
            end else if (!osc_sleep) begin
                n.hi[i] = output_drive_type && !v;
                n.lo[i] = v;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{hi: RST_HI, lo: RST_LO, default: '0};
        end else begin
            s <= n;
        end
    end

    assign led_hi_on = s.hi;
    assign led_lo_on = s.lo;

    // ********************************
    // checks
    // ********************************
    default clocking @(posedge clk);
    endclocking

    default disable iff (!rst_n);

    property p_sleep_hold;
        osc_sleep && !s.oe_f |=> $stable(s.ind_cnt) && $stable(s.grp_cnt) && $stable(led_lo_on);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("counting while asleep");

    property p_disable_low;
        s.oe_f && disabled_output_state == DIS_LOW |=> led_lo_on == 4'hF && led_hi_on == 4'h0;
    endproperty
    a_disable_low: assert property (p_disable_low) else $error("disabled state wrong");

    // state leaves reset one edge after rst_n rises
    property p_ind_step;
        rst_n && !osc_sleep |=> s.ind_cnt == 8'($past(s.ind_cnt) + 8'h1);
    endproperty
    a_ind_step: assert property (p_ind_step) else $error("pwm step missed");

    property p_combined_totem;
        !s.oe_f && !osc_sleep && channel_output_select[1:0] == 2'h3 && !output_polarity_invert
            && output_drive_type
            |=> led_lo_on[0] == $past((s.ind_cnt < channel_duty_value[7:0]) && grp_act)
            && led_hi_on[0] == !led_lo_on[0];
    endproperty
    a_combined_totem: assert property (p_combined_totem) else $error("combined totem wrong");

    property p_inv_od;
        !s.oe_f && !osc_sleep && channel_output_select[1:0] == SEL_IND && output_polarity_invert
            && !output_drive_type
            |=> !led_hi_on[0] && led_lo_on[0] == !$past(s.ind_cnt < channel_duty_value[7:0]);
    endproperty
    a_inv_od: assert property (p_inv_od) else $error("inverted open-drain wrong");

    property p_inv_totem;
        !s.oe_f && !osc_sleep && channel_output_select[1:0] == SEL_IND && output_polarity_invert
            && output_drive_type
            |=> led_hi_on[0] == $past(s.ind_cnt < channel_duty_value[7:0]) && led_lo_on[0] == !led_hi_on[0];
    endproperty
    a_inv_totem: assert property (p_inv_totem) else $error("inverted totem wrong");

    property p_dim_step;
        !group_blink && !osc_sleep && s.grp_pre == 12'(DIM_STEP_CYC - 1)
            |=> s.grp_pre == 12'h0 && s.grp_cnt == 8'($past(s.grp_cnt) + 8'h1);
    endproperty
    a_dim_step: assert property (p_dim_step) else $error("dim step wrong");

    property p_blink_hold;
        group_blink && !osc_sleep && lpwm_wrap(s.grp_pre, BLINK_STEP_CYC) && s.grp_sub < group_period_value
            |=> $stable(s.grp_cnt);
    endproperty
    a_blink_hold: assert property (p_blink_hold) else $error("blink step early");

endmodule : lpwm_top
`default_nettype wire

// file: tb/lpwm_i2c_ctrl.sv
// serial bus controller model driving clock and data towards the led stage
`timescale 1ns/1ns
`default_nettype none
module lpwm_i2c_ctrl #(
    parameter int HIGH_NS = 150, // clock high phase
    parameter int LOW_NS = 250 // low phase; the target answers ~4 clk after a fall
) (
    input wire logic sda_line, // resolved data line
    output logic scl, // serial clock, stands high outside frames
    output logic sda_rel // 1 releases data, 0 pulls low
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic start_c;
        sda_rel = 1'b0;
        #HIGH_NS;
        scl = 1'b0;
    endtask : start_c

    // data only moves while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        #(LOW_NS - 100);
        sda_rel = b;
        #100;
        scl = 1'b1;
        #(HIGH_NS / 2);
        s = sda_line;
        #(HIGH_NS / 2);
        scl = 1'b0;
    endtask : clk_bit

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, ack);
    endtask : send_byte

    task automatic recv_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(!ack_it, s);
    endtask : recv_byte

    task automatic stop_c;
        #(LOW_NS - 100);
        sda_rel = 1'b0;
        #100;
        scl = 1'b1;
        #HIGH_NS;
        sda_rel = 1'b1;
        #HIGH_NS;
    endtask : stop_c
endmodule : lpwm_i2c_ctrl
`default_nettype wire

// file: tb/lpwm_top_tb.sv
// self-checking bench of the led pwm output stage and its serial target
`timescale 1ns/1ns
`default_nettype none
module lpwm_top_tb;
    localparam logic [6:0] DEV = 7'h2A; // arbitrary target address
    typedef struct packed {
        logic [1:0] sel;
        logic inv;
        logic drv;
        logic blink;
        logic [7:0] duty;
        logic [7:0] gd;
        logic [3:0] hi;
        logic [3:0] lo;
    } lpwm_row_s;
    lpwm_row_s rows[13] = '{
        '{2'h0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 4'hF, 4'h0},
        '{2'h1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 4'h0, 4'hF},
        '{2'h1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 4'hF, 4'h0},
        '{2'h1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 4'h0},
        '{2'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 4'hF},
        '{2'h0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 4'h0},
        '{2'h0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 4'hF},
        '{2'h2, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 4'hF, 4'h0},
        '{2'h3, 1'b0, 1'b1, 1'b0, 8'hFF, 8'h00, 4'hF, 4'h0},
        '{2'h3, 1'b0, 1'b1, 1'b1, 8'hFF, 8'h00, 4'hF, 4'h0},
        '{2'h2, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 4'h0, 4'hF},
        '{2'h2, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 4'hF},
        '{2'h3, 1'b1, 1'b1, 1'b0, 8'h00, 8'hFF, 4'h0, 4'hF}
    };
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic oe_n_pin = 1'b0;
    logic osc_sleep = 1'b0;
    logic group_blink = 1'b0;
    logic inv = 1'b0;
    logic drv = 1'b1;
    logic [1:0] dis = 2'h0;
    logic [7:0] sel = 8'h00;
    logic [31:0] duty = 32'h0;
    logic [7:0] gduty = 8'h00;
    logic [7:0] gper = 8'h00;
    logic [7:0] tx_byte = 8'hC3;
    logic [7:0] rx_byte;
    logic rx_valid, rx_first, tx_taken, bus_busy, sda_out, sda_oe_n, scl, sda_rel;
    logic [3:0] led_hi_on, led_lo_on;
    wire logic sda_line = sda_rel & (sda_oe_n | sda_out);
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int rx_cnt = 0;
    int tx_cnt = 0;

    lpwm_top #(.DEV_ADDR(DEV)) i_lpwm_top (.clk(clk), .arst_n(arst_n), .scl_pin(scl), .sda_pin_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .oe_n_pin(oe_n_pin), .osc_sleep(osc_sleep),
        .group_blink(group_blink), .output_polarity_invert(inv), .output_drive_type(drv),
        .disabled_output_state(dis), .channel_output_select(sel), .channel_duty_value(duty),
        .group_duty_value(gduty), .group_period_value(gper), .tx_byte(tx_byte), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_first(rx_first), .tx_taken(tx_taken), .bus_busy(bus_busy),
        .led_hi_on(led_hi_on), .led_lo_on(led_lo_on));
    lpwm_i2c_ctrl i_lpwm_i2c_ctrl (.sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

    // ********************************
    // clock, timeout, checks
    // ********************************
    initial begin
        forever #25 clk = ~clk;
    end

    always @(negedge clk) begin
        cyc++;
        if (rx_valid === 1'b1) rx_cnt++;
        if (tx_taken === 1'b1) tx_cnt++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_pins(input logic [3:0] ehi, input logic [3:0] elo);
        compares++;
        if ({led_hi_on, led_lo_on} !== {ehi, elo}) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {led_hi_on, led_lo_on}, {ehi, elo});
        end
    endtask : chk_pins

    task automatic stop_test;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // ********************************
    // main sequence
    // ********************************
    initial begin
        logic ack;
        logic [7:0] b;
        logic [15:0] hcnt[4];
        logic [15:0] nchg;
        logic [7:0] snap;
        repeat (10) @(negedge clk);
        chk_pins(4'hF, 4'h0);
        chk_val({14'h0, sda_oe_n, bus_busy}, 16'h0002);
        arst_n = 1'b1;
        repeat (10) @(negedge clk);
        $display("test reset done");
        foreach (rows[r]) begin
            sel = {4{rows[r].sel}};
            inv = rows[r].inv;
            drv = rows[r].drv;
            group_blink = rows[r].blink;
            duty = {4{rows[r].duty}};
            gduty = rows[r].gd;
            repeat (4) @(negedge clk);
            chk_pins(rows[r].hi, rows[r].lo);
        end
        $display("test table done");
        // different duty per channel, boundary values included
        sel = 8'hAA;
        inv = 1'b0;
        duty = 32'h80FF0140;
        repeat (4) @(negedge clk);
        hcnt = '{default: 16'h0};
        for (int c = 0; c < 256; c++) begin
            @(negedge clk);
            for (int k = 0; k < 4; k++) hcnt[k] += {15'h0, led_lo_on[k]};
        end
        for (int k = 0; k < 4; k++) chk_val(hcnt[k], {8'h0, duty[8*k+:8]});
        $display("test duty done");
        oe_n_pin = 1'b1;
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 2; d++) begin
                dis = s[1:0];
                drv = d[0];
                repeat (8) @(negedge clk);
                chk_pins((s == 1 && d == 1) ? 4'hF : 4'h0, (s == 0) ? 4'hF : 4'h0);
            end
        end
        oe_n_pin = 1'b0;
        drv = 1'b1;
        $display("test disable done");
        repeat (8) @(negedge clk);
        osc_sleep = 1'b1;
        repeat (4) @(negedge clk);
        snap = {led_hi_on, led_lo_on};
        nchg = 16'h0;
        repeat (300) begin
            @(negedge clk);
            if ({led_hi_on, led_lo_on} !== snap) nchg++;
        end
        chk_val(nchg, 16'h0);
        osc_sleep = 1'b0;
        $display("test sleep done");
        i_lpwm_i2c_ctrl.start_c();
        repeat (8) @(negedge clk);
        chk_val({15'h0, bus_busy}, 16'h1);
        i_lpwm_i2c_ctrl.send_byte({DEV, 1'b0}, ack);
        chk_val({15'h0, ack}, 16'h0);
        i_lpwm_i2c_ctrl.send_byte(8'hA5, ack);
        chk_val({7'h0, ack, rx_byte}, 16'h00A5);
        chk_val({15'h0, rx_first}, 16'h1);
        i_lpwm_i2c_ctrl.send_byte(8'h3C, ack);
        chk_val({6'h0, ack, rx_first, rx_byte}, 16'h003C);
        i_lpwm_i2c_ctrl.stop_c();
        repeat (8) @(negedge clk);
        chk_val({15'h0, bus_busy}, 16'h0);
        chk_val(rx_cnt[15:0], 16'h2);
        $display("test write done");
        i_lpwm_i2c_ctrl.start_c();
        i_lpwm_i2c_ctrl.send_byte({DEV ^ 7'h01, 1'b0}, ack);
        chk_val({15'h0, ack}, 16'h1);
        i_lpwm_i2c_ctrl.stop_c();
        i_lpwm_i2c_ctrl.start_c();
        i_lpwm_i2c_ctrl.send_byte({DEV, 1'b1}, ack);
        chk_val({15'h0, ack}, 16'h0);
        i_lpwm_i2c_ctrl.recv_byte(1'b1, b);
        chk_val({8'h0, b}, 16'h00C3);
        tx_byte = 8'h5A;
        i_lpwm_i2c_ctrl.recv_byte(1'b0, b);
        chk_val({8'h0, b}, 16'h005A);
        repeat (8) @(negedge clk);
        chk_val({15'h0, sda_oe_n}, 16'h1);
        i_lpwm_i2c_ctrl.stop_c();
        chk_val(tx_cnt[15:0], 16'h2);
        $display("test read done");
        sel = 8'hFF;
        duty = 32'hFFFFFFFF;
        gduty = 8'h00;
        gper = 8'h01;
        group_blink = 1'b1;
        // long enough for one blink prescaler wrap
        repeat (3300) @(negedge clk);
        chk_pins(4'hF, 4'h0);
        $display("test blink done");
        sel = 8'h55;
        arst_n = 1'b0;
        @(negedge clk);
        chk_pins(4'hF, 4'h0);
        chk_val({14'h0, sda_oe_n, bus_busy}, 16'h0002);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk_pins(4'hF, 4'h0);
        @(negedge clk);
        chk_pins(4'h0, 4'hF);
        $display("test mid reset done");
        stop_test();
    end
endmodule : lpwm_top_tb
`default_nettype wire
